//--- verilog/backplane_defs.svh
`ifndef BACKPLANE_DEFS_SVH
`define BACKPLANE_DEFS_SVH

// clock periods, in ns
`define CORE_CLK_PERIOD_NS  8
`define BP_CLK_PERIOD_NS    100

// half period of the self-made backplane clock, rounded down
`define BP_HALF_CYCLES      ((`BP_CLK_PERIOD_NS / 2) / `CORE_CLK_PERIOD_NS)

// backplane clock falls with the bus held before the first data bit
`define ACQUIRE_BCLKS       3'h2

// core cycles with all lines released after a transmission
`define HOLDOFF_CYCLES      3'h4

// core cycles after reset release before the mode strap is taken
`define STRAP_SETTLE        2'h3

// mode strap level after reset, before it is sampled (pull-up side)
`define STRAP_RESET_LEVEL   1'h1

// positions of the pins in the synchroniser vector
`define PIN_CLK             0
`define PIN_GRANT           1
`define PIN_DATA            2
`define PIN_CFS             3
`define PIN_COL             4
`define PIN_MODE            5
`define PIN_COUNT           6

`endif

//--- verilog/backplane_pkg.sv
package backplane_pkg;

	// one bit of a packet with its end mark
	typedef struct packed {
		logic last;
		logic bit_val;
	} bp_word_s;

	// levels seen on the shared backplane lines
	typedef struct packed {
		logic backplane_collision_line;
		logic collision_flag_sense;
		logic backplane_data_line;
		logic backplane_bus_grant_n;
		logic backplane_clock_line;
	} bp_lines_s;

	// port state machine
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ACQUIRE = 3'b001,
		ST_SEND    = 3'b010,
		ST_RECEIVE = 3'b011,
		ST_HOLDOFF = 3'b100
	} bp_state_e;

endpackage

//--- verilog/bp_fifo.sv
`timescale 1ns/10ps

module bp_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// honest full and empty from the word count
	assign in_ready  = (count_r != (AW+1)'(DEPTH)); // full at DEPTH words
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

//--- verilog/backplane_port.sv
// Summary of operation
// - data on the backplane is timed by a backplane clock of about 10 MHz.
// - in asynchronous mode the clock line carries a clock only while someone sends and is released otherwise.
// - in asynchronous mode the port that holds the bus puts its own clock on the clock line.
// - a port that is not sending follows the sender's clock until the bus is given up.
// - a high or floating mode strap selects asynchronous mode and a low strap selects synchronous mode.
// - the port pulls the bus grant line before sending and also watches that line as an input.
// - packet data goes out and comes in one bit at a time on the single shared data line.
// - the driver enable output is held low for the whole transmission.
// - every port joins collision signalling on the collision line; only the sending port pulls the flag sense line, the others watch it.
// - the mode strap is sampled once, a few core cycles after reset is released.
// - the sender puts retimed data on the backplane so all repeaters rebroadcast it together.
`timescale 1ns/10ps
`include "backplane_defs.svh"

module backplane_port #(
	parameter int FIFO_DEPTH = 4,
	parameter int HALF_CYCLES = `BP_HALF_CYCLES
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// core transmit stream
	input  wire logic                   tx_valid,
	output logic                        tx_ready,
	input  wire backplane_pkg::bp_word_s tx_word,
	// core receive stream
	output logic                        rx_valid,
	output logic                        rx_bit,
	output logic                        rx_end,
	output logic                        rx_active,
	// core collision and status
	input  wire logic                   local_collision,
	output logic                        bp_collision,
	output logic                        flag_seen,
	output logic                        tx_collide,
	output logic                        async_mode,
	// mode strap pin
	input  wire logic                   mode_select,
	// backplane lines, open drain
	input  wire backplane_pkg::bp_lines_s bp_in,
	output backplane_pkg::bp_lines_s    bp_out,
	output backplane_pkg::bp_lines_s    bp_oe,
	// external buffer enable
	output logic                        external_driver_enable_n
);

	localparam int DW = $bits(backplane_pkg::bp_word_s);

	backplane_pkg::bp_state_e state_r;
	backplane_pkg::bp_state_e state_nxt;
	backplane_pkg::bp_word_s  fifo_word;

	logic [`PIN_COUNT-1:0] pin_raw;
	logic [`PIN_COUNT-1:0] meta_r;
	logic [`PIN_COUNT-1:0] sync_r;
	logic                  lclk_d_r;
	logic                  lclk_rise;
	logic                  lclk_fall;
	logic [1:0]            strap_cnt_r;
	logic                  strap_done_r;
	logic                  async_mode_r;
	logic [3:0]            div_cnt_r;
	logic                  own_clk_r;
	logic                  own_rise_r;
	logic                  own_fall_r;
	logic                  sending;
	logic                  tx_rise;
	logic                  tx_fall;
	logic                  fifo_valid;
	logic                  fifo_pop;
	logic [2:0]            acq_cnt_r;
	logic [2:0]            hold_cnt_r;
	logic                  bit_r;
	logic                  last_sent_r;
	logic                  collide_r;
	logic                  rx_valid_r;
	logic                  rx_bit_r;
	logic                  rx_end_r;
	logic                  bp_col_r;
	logic                  flag_r;
	logic                  drv_en_n_r;
	logic                  other_owner;

	// transmit buffer between the core and the line
	bp_fifo #(
		.WIDTH (DW),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_word),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_word)
	);

	// every pin crosses two flip-flops before use
	assign pin_raw = {mode_select,
	                  bp_in.backplane_collision_line,
	                  bp_in.collision_flag_sense,
	                  bp_in.backplane_data_line,
	                  bp_in.backplane_bus_grant_n,
	                  bp_in.backplane_clock_line};

	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					meta_r[gi] <= 1'b1;
					sync_r[gi] <= 1'b1;
				end else begin
					meta_r[gi] <= pin_raw[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	// edges of the backplane clock as seen on the line
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lclk_d_r <= 1'b1;
		end else begin
			lclk_d_r <= sync_r[`PIN_CLK];
		end
	end

	assign lclk_rise = sync_r[`PIN_CLK] & ~lclk_d_r;
	assign lclk_fall = ~sync_r[`PIN_CLK] & lclk_d_r;

	// mode strap taken once, shortly after reset release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			async_mode_r <= `STRAP_RESET_LEVEL;
		end else if (!strap_done_r) begin
			if (strap_cnt_r == `STRAP_SETTLE) begin
				strap_done_r <= 1'b1;
				async_mode_r <= sync_r[`PIN_MODE];
			end else begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
			end
		end
	end

	assign sending = (state_r == backplane_pkg::ST_ACQUIRE) || (state_r == backplane_pkg::ST_SEND);

	// own backplane clock, runs only while this port holds the bus in async mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_r  <= 4'h0;
			own_clk_r  <= 1'b1;
			own_rise_r <= 1'b0;
			own_fall_r <= 1'b0;
		end else if (sending && async_mode_r) begin
			own_rise_r <= 1'b0;
			own_fall_r <= 1'b0;
			if (div_cnt_r == 4'(HALF_CYCLES - 1)) begin
				div_cnt_r  <= 4'h0;
				own_clk_r  <= ~own_clk_r;
				own_rise_r <= ~own_clk_r;
				own_fall_r <= own_clk_r;
			end else begin
				div_cnt_r <= div_cnt_r + 4'h1;
			end
		end else begin
			div_cnt_r  <= 4'h0;
			own_clk_r  <= 1'b1;
			own_rise_r <= 1'b0;
			own_fall_r <= 1'b0;
		end
	end

	// sync mode times the send from the line clock, async from the own clock
	assign tx_rise = async_mode_r ? own_rise_r : lclk_rise;
	assign tx_fall = async_mode_r ? own_fall_r : lclk_fall;

	// grant low while this port is not driving means another sender
	assign other_owner = ~sync_r[`PIN_GRANT] & ~sending;

	// pop one word per bit slot once the bus is held
	assign fifo_pop = (state_r == backplane_pkg::ST_SEND) && tx_fall && !last_sent_r && fifo_valid;

	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			backplane_pkg::ST_IDLE: begin
				if (other_owner) begin
					state_nxt = backplane_pkg::ST_RECEIVE;
				end else if (fifo_valid && strap_done_r) begin
					state_nxt = backplane_pkg::ST_ACQUIRE;
				end
			end
			backplane_pkg::ST_ACQUIRE: begin
				if (tx_fall && acq_cnt_r == `ACQUIRE_BCLKS - 3'h1) begin
					state_nxt = backplane_pkg::ST_SEND;
				end
			end
			backplane_pkg::ST_SEND: begin
				if (tx_fall && (last_sent_r || !fifo_valid)) begin
					state_nxt = backplane_pkg::ST_HOLDOFF;
				end
			end
			backplane_pkg::ST_RECEIVE: begin
				if (sync_r[`PIN_GRANT]) begin
					state_nxt = backplane_pkg::ST_IDLE;
				end
			end
			backplane_pkg::ST_HOLDOFF: begin
				if (hold_cnt_r == `HOLDOFF_CYCLES - 3'h1) begin
					state_nxt = backplane_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = backplane_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= backplane_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// acquire and holdoff counters
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acq_cnt_r  <= 3'h0;
			hold_cnt_r <= 3'h0;
		end else begin
			if (state_r != backplane_pkg::ST_ACQUIRE) begin
				acq_cnt_r <= 3'h0;
			end else if (tx_fall) begin
				acq_cnt_r <= acq_cnt_r + 3'h1;
			end
			if (state_r != backplane_pkg::ST_HOLDOFF) begin
				hold_cnt_r <= 3'h0;
			end else begin
				hold_cnt_r <= hold_cnt_r + 3'h1;
			end
		end
	end

	// transmit bit, changed on the falling clock so receivers sample mid bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_r       <= 1'b1;
			last_sent_r <= 1'b0;
		end else if (state_r != backplane_pkg::ST_SEND) begin
			bit_r       <= 1'b1;
			last_sent_r <= 1'b0;
		end else if (fifo_pop) begin
			bit_r       <= fifo_word.bit_val;
			last_sent_r <= fifo_word.last;
		end
	end

	// another driver seen: line low while this port released it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			collide_r <= 1'b0;
		end else if (state_r == backplane_pkg::ST_SEND && tx_rise && bit_r && !sync_r[`PIN_DATA]) begin
			collide_r <= 1'b1;
		end else if (state_r == backplane_pkg::ST_IDLE) begin
			collide_r <= 1'b0;
		end
	end

	// receive path follows the sender's clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_valid_r <= 1'b0;
			rx_bit_r   <= 1'b0;
			rx_end_r   <= 1'b0;
		end else begin
			rx_valid_r <= (state_r == backplane_pkg::ST_RECEIVE) && lclk_rise && !sync_r[`PIN_GRANT];
			rx_end_r   <= (state_r == backplane_pkg::ST_RECEIVE) && sync_r[`PIN_GRANT];
			if ((state_r == backplane_pkg::ST_RECEIVE) && lclk_rise) begin
				rx_bit_r <= sync_r[`PIN_DATA];
			end
		end
	end

	// collision status and external buffer enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bp_col_r   <= 1'b0;
			flag_r     <= 1'b0;
			drv_en_n_r <= 1'b1;
		end else begin
			bp_col_r   <= ~sync_r[`PIN_COL];
			flag_r     <= ~sync_r[`PIN_CFS];
			drv_en_n_r <= ~(state_nxt == backplane_pkg::ST_ACQUIRE || state_nxt == backplane_pkg::ST_SEND);
		end
	end

	// core side outputs
	assign rx_valid      = rx_valid_r;
	assign rx_bit        = rx_bit_r;
	assign rx_end        = rx_end_r;
	assign rx_active     = (state_r == backplane_pkg::ST_RECEIVE);
	assign bp_collision  = bp_col_r;
	assign flag_seen     = flag_r;
	assign tx_collide    = collide_r;
	assign async_mode    = async_mode_r;
	assign external_driver_enable_n = drv_en_n_r;

	// shared lines are only ever pulled low
	assign bp_out = '0;

	// output enables of the open-drain lines
	assign bp_oe.backplane_clock_line     = sending & async_mode_r & ~own_clk_r;
	assign bp_oe.backplane_bus_grant_n    = sending;
	assign bp_oe.backplane_data_line      = (state_r == backplane_pkg::ST_SEND) & ~bit_r;
	assign bp_oe.collision_flag_sense     = sending;
	assign bp_oe.backplane_collision_line = (sending & collide_r) | local_collision;

endmodule

//--- bench/backplane_port_asserts.sv
`timescale 1ns/10ps

module backplane_port_asserts (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     arst_n,
	// status and strap
	input wire logic                     rx_active,
	input wire logic                     local_collision,
	input wire logic                     bp_collision,
	input wire logic                     flag_seen,
	input wire logic                     async_mode,
	input wire logic                     mode_select,
	// backplane lines
	input wire backplane_pkg::bp_lines_s bp_in,
	input wire backplane_pkg::bp_lines_s bp_out,
	input wire backplane_pkg::bp_lines_s bp_oe,
	input wire logic                     external_driver_enable_n
);
	logic [3:0] up_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// cycles since reset release, saturating
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			up_r <= 4'h0;
		else if (up_r != 4'hF)
			up_r <= up_r + 4'h1;
	end

	a_only_low: assert property (bp_out == 5'h00)
		else $error("shared line driven high");
	a_den_send: assert property (bp_oe.backplane_data_line |-> !external_driver_enable_n)
		else $error("data sent without buffer enable");
	a_rx_quiet: assert property (rx_active |-> !bp_oe.backplane_data_line && !bp_oe.backplane_bus_grant_n)
		else $error("port drives while receiving");
	a_clk_owned: assert property (bp_oe.backplane_clock_line |-> bp_oe.backplane_bus_grant_n && async_mode)
		else $error("clock driven without bus or in sync mode");
	a_local_col: assert property (local_collision [*2] |-> bp_oe.backplane_collision_line)
		else $error("core collision not signalled");
	a_col_seen: assert property (!bp_in.backplane_collision_line [*4] |-> bp_collision)
		else $error("collision line low not reported");
	a_flag_seen: assert property (!bp_in.collision_flag_sense [*4] |-> flag_seen)
		else $error("flag sense low not reported");
	a_strap_take: assert property (up_r == 4'h8 |-> async_mode == mode_select)
		else $error("mode strap not taken");
	a_strap_hold: assert property (up_r > 4'h8 |-> $stable(async_mode))
		else $error("mode changed after strap");
endmodule

//--- bench/bp_partner.sv
`timescale 1ns/10ps

module bp_partner (
	// control from the bench
	input wire logic       go,
	input wire logic       jam,
	input wire logic       run,
	input wire logic [7:0] pat,
	// open drain pulls
	output backplane_pkg::bp_lines_s oe
);
	logic g_r, c_r, d_r, f_r;

	// pulls only, high comes from pull-ups; flag sense held with the bus
	assign oe = {1'b0, g_r, d_r | jam, g_r, c_r | f_r};

	initial begin
		g_r = 1'b0;
		c_r = 1'b0;
		d_r = 1'b0;
		f_r = 1'b0;
	end

	// common source clock in synchronous mode, free running, locked to the core clock
	always @(posedge run) begin
		while (run) begin
			f_r = 1'b1;
			#32;
			f_r = 1'b0;
			#32;
		end
	end

	// one frame of eight bits, clock only inside the frame
	always @(posedge go) begin
		g_r = 1'b1;
		#64;
		for (int i = 0; i < 8; i++) begin
			c_r = 1'b1;
			d_r = ~pat[i];
			#32;
			c_r = 1'b0;
			#32;
		end
		#32;
		d_r = 1'b0;
		g_r = 1'b0;
	end
endmodule

//--- bench/backplane_port_tb.sv
`timescale 1ns/10ps
`define CHK(n, g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %0h seen %0h", n, e, g); end end

module backplane_port_tb;
	logic clk, arst_n, tx_valid, tx_ready, rx_valid, rx_bit, rx_end, rx_active;
	logic loc_col, bp_collision, flag_seen, tx_collide, async_mode, mode_select;
	logic den_n, go, jam, run, line_clk_d;
	logic [7:0] pat;
	backplane_pkg::bp_word_s tx_word;
	backplane_pkg::bp_lines_s line, bp_out, bp_oe, p_oe;
	int n_errors = 0, checked = 0, seed = 49, n_end = 0, k;
	logic q_seen[$], q_rx[$], q_exp[$];

	// wire is low while any party pulls it
	assign line = backplane_pkg::bp_lines_s'(~(bp_oe | p_oe));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	backplane_port backplane_port_inst (.clk, .arst_n, .tx_valid, .tx_ready, .tx_word, .rx_valid, .rx_bit,
		.rx_end, .rx_active, .local_collision(loc_col), .bp_collision, .flag_seen, .tx_collide, .async_mode,
		.mode_select, .bp_in(line), .bp_out, .bp_oe, .external_driver_enable_n(den_n));
	bp_partner bp_partner_inst (.go, .jam, .run, .pat, .oe(p_oe));

	// line bits at every rise of the line clock while we hold the bus, and received bits
	always @(posedge clk) begin
		line_clk_d <= line.backplane_clock_line;
		if (!line_clk_d && line.backplane_clock_line && bp_oe.backplane_bus_grant_n)
			q_seen.push_back(line.backplane_data_line);
		if (rx_valid === 1'b1)
			q_rx.push_back(rx_bit);
		if (rx_end === 1'b1)
			n_end++;
	end

	task automatic give_verdict;
		$display("counts: %0d checked, %0d errors", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic guard(input int i);
		if (i >= 2000) begin
			n_errors++;
			$display("wrong value wait bound exp 1 seen 0");
			give_verdict();
		end
	endtask

	task automatic do_reset(input logic m);
		arst_n = 1'b0;
		mode_select = m;
		repeat (12) @(negedge clk);
		`CHK("async_mode in reset", async_mode, 1'b1)
		arst_n = 1'b1;
		repeat (8) @(negedge clk);
		`CHK("async_mode", async_mode, m)
		$display("test strap %0d done", m);
	endtask

	// offer one word, wait until taken
	task automatic push(input logic l, input logic b);
		tx_valid = 1'b1;
		tx_word = '{last: l, bit_val: b};
		for (k = 0; k < 2000 && tx_ready !== 1'b1; k++) @(negedge clk);
		guard(k);
		q_exp.push_back(b);
		@(negedge clk);
	endtask

	task automatic send(input int n, input logic j);
		q_exp = {};
		q_seen = {};
		jam = j;
		for (int i = 0; i < n; i++) begin
			push(i == n - 1, j | 1'($random(seed)));
			if (i == 3) `CHK("tx_ready full", tx_ready, 1'b0)
		end
		tx_valid = 1'b0;
		for (k = 0; k < 2000 && bp_oe.backplane_bus_grant_n !== 1'b1; k++) @(negedge clk);
		guard(k);
		`CHK("driver enable", den_n, 1'b0)
		for (k = 0; k < 2000 && bp_oe.backplane_bus_grant_n !== 1'b0; k++) @(negedge clk);
		guard(k);
		`CHK("driver enable off", den_n, 1'b1)
		`CHK("tx_collide", tx_collide, j)
		while (q_seen.size() > q_exp.size()) q_seen.pop_front();
		if (!j) `CHK("bits on line", q_seen == q_exp, 1'b1)
		jam = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("tx_collide idle", tx_collide, 1'b0)
		$display("test send %0d jam %0d done", n, j);
	endtask

	task automatic receive;
		q_rx = {};
		q_exp = {};
		n_end = 0;
		pat = 8'($random(seed));
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		for (k = 0; k < 2000 && rx_active !== 1'b1; k++) @(negedge clk);
		guard(k);
		`CHK("flag_seen", flag_seen, 1'b1)
		for (k = 0; k < 2000 && n_end == 0; k++) @(negedge clk);
		guard(k);
		for (int i = 0; i < 8; i++) q_exp.push_back(pat[i]);
		`CHK("received bits", q_rx == q_exp, 1'b1)
		`CHK("rx_active", rx_active, 1'b0)
		$display("test receive done");
	endtask

	initial begin
		arst_n = 1'b0;
		tx_valid = 1'b0;
		tx_word = '0;
		loc_col = 1'b0;
		mode_select = 1'b0;
		go = 1'b0;
		jam = 1'b0;
		run = 1'b0;
		pat = '0;
		do_reset(1'b0);
		do_reset(1'b1);
		send(8, 1'b0);
		send(1, 1'b0);
		receive();
		loc_col = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("collision pull", bp_oe.backplane_collision_line, 1'b1)
		`CHK("bp_collision", bp_collision, 1'b1)
		loc_col = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("bp_collision clear", bp_collision, 1'b0)
		$display("test collision done");
		send(4, 1'b1);
		do_reset(1'b0);
		run = 1'b1;
		send(8, 1'b0);
		run = 1'b0;
		give_verdict();
	end
endmodule

bind backplane_port backplane_port_asserts chk_inst (.clk, .arst_n, .rx_active, .local_collision, .bp_collision,
	.flag_seen, .async_mode, .mode_select, .bp_in, .bp_out, .bp_oe, .external_driver_enable_n);
